// ==== rtl/payload_error_inserter.v ====
// transmit payload error inserter for a T1 framer, APB register slave
// assumes tx stream is in the pclk domain, one bit per tx_bit_valid,
// with tx_frame_bit marking the framing bit and tx_channel its DS0
`timescale 1ns/100ps

// Summary of operation
// - only transmit payload bits are corrupted, receive path untouched
// - errors hit all channels or only host-selected DS0 channels
// - last bit of each counted group is inverted, e.g. 16th of 16
// - framing bits are not counted and never inverted
// - a new rate code takes effect at the next frame boundary
// - rate code 0 inserts none; 1..15 give 1 in 16 up to 262144
// - constant bit with non-zero rate ignores count, inserts forever
// - rate code zero means no errors even in constant mode
// - count mode inserts exactly the last transferred count
// - rising load strobe transfers the count on the next cycle
// - holding load strobe high gives no reload; host must re-toggle
// - count is 10 bits: low register bits 7:0, high bits 9:8
// - count zero makes no errors, count n makes exactly n
// - remaining count readable at any time in two read-only registers
module payload_error_inserter #(
  parameter CNT_W = 18
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        tx_bit_valid,
  input  wire        tx_bit_in,
  input  wire        tx_frame_bit,
  input  wire [4:0]  tx_channel,
  output reg         tx_bit_valid_out,
  output reg         tx_bit_out,
  output reg         error_inserted
);
  `include "payload_error_inserter_regs.vh"

  reg  [7:0]  erc_ff;
  reg  [7:0]  cnt_low_ff;
  reg  [1:0]  cnt_high_ff;
  reg  [23:0] chan_sel_ff;
  reg         per_chan_ff;
  reg         load_prev_ff;
  reg         load_pend_ff;
  reg  [3:0]  rate_ff;
  reg  [9:0]  left_ff;
  reg  [9:0]  nxt_left;
  reg  [31:0] nxt_rdata;
  reg         addr_hit;

  wire       wr_en;
  wire       rd_en;
  wire [9:0] word_idx;
  wire       chan_ok;
  wire       bit_en;
  wire       group_end;
  wire       active;
  wire       inject;
  wire       const_mode;
  wire       load_rise;

  function is_idx;
    input [9:0] idx;
    input [7:0] reg_idx;
    begin
      is_idx = (idx == {2'h0, reg_idx});
    end
  endfunction

  // zero wait states; unmapped addresses read zero and report pslverr
  assign pready   = 1'b1;
  assign word_idx = paddr[11:2];
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign pslverr  = psel && penable && !addr_hit;

  always @* begin
    addr_hit = is_idx(word_idx, `IDX_ERROR_RATE_CONTROL) ||
      is_idx(word_idx, `IDX_ERROR_COUNT_LOW) ||
      is_idx(word_idx, `IDX_ERROR_COUNT_HIGH) ||
      is_idx(word_idx, `IDX_ERRORS_LEFT_LOW) ||
      is_idx(word_idx, `IDX_ERRORS_LEFT_HIGH) ||
      is_idx(word_idx, `IDX_CHANNEL_SELECT) ||
      is_idx(word_idx, `IDX_CONTROL);
  end

  always @* begin
    nxt_rdata = 32'h00000000;
    if (is_idx(word_idx, `IDX_ERROR_RATE_CONTROL)) begin
      nxt_rdata[7:0] = erc_ff;
    end else if (is_idx(word_idx, `IDX_ERROR_COUNT_LOW)) begin
      nxt_rdata[7:0] = cnt_low_ff;
    end else if (is_idx(word_idx, `IDX_ERROR_COUNT_HIGH)) begin
      nxt_rdata[1:0] = cnt_high_ff;
    end else if (is_idx(word_idx, `IDX_ERRORS_LEFT_LOW)) begin
      nxt_rdata[7:0] = left_ff[7:0];
    end else if (is_idx(word_idx, `IDX_ERRORS_LEFT_HIGH)) begin
      nxt_rdata[1:0] = left_ff[9:8];
    end else if (is_idx(word_idx, `IDX_CHANNEL_SELECT)) begin
      nxt_rdata[23:0] = chan_sel_ff;
    end else if (is_idx(word_idx, `IDX_CONTROL)) begin
      nxt_rdata[0] = per_chan_ff;
    end
  end

  // read data captured in setup, stable through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= nxt_rdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erc_ff      <= `RST_ERROR_RATE_CONTROL;
      cnt_low_ff  <= `RST_ERROR_COUNT_LOW;
      cnt_high_ff <= 2'h0;
      chan_sel_ff <= `RST_CHANNEL_SELECT;
      per_chan_ff <= `RST_CONTROL;
    end else if (wr_en) begin
      if (is_idx(word_idx, `IDX_ERROR_RATE_CONTROL)) begin
        // bits 5 and 6 are unused and kept at zero
        erc_ff <= pwdata[7:0] & `ERC_WRITE_MASK;
      end
      if (is_idx(word_idx, `IDX_ERROR_COUNT_LOW)) begin
        cnt_low_ff <= pwdata[7:0];
      end
      if (is_idx(word_idx, `IDX_ERROR_COUNT_HIGH)) begin
        cnt_high_ff <= pwdata[1:0];
      end
      if (is_idx(word_idx, `IDX_CHANNEL_SELECT)) begin
        chan_sel_ff <= pwdata[23:0];
      end
      if (is_idx(word_idx, `IDX_CONTROL)) begin
        per_chan_ff <= pwdata[0];
      end
    end
  end

  assign const_mode = erc_ff[`ERC_CONST_BIT];
  // only a 0 to 1 change of the stored bit counts, not a held level
  assign load_rise = erc_ff[`ERC_LOAD_BIT] && !load_prev_ff;

  // framing bits never advance the spacing count
  assign chan_ok = !per_chan_ff ||
    ((tx_channel < 5'd24) && chan_sel_ff[tx_channel]);
  assign bit_en = tx_bit_valid && !tx_frame_bit && chan_ok;

  error_spacing_counter #(
    .CNT_W     (CNT_W)
  ) u_spacing (
    .pclk      (pclk),
    .presetn   (presetn),
    .bit_en    (bit_en),
    .restart   (load_pend_ff),
    .rate_code (rate_ff),
    .group_end (group_end)
  );

  // rate zero blocks both modes; count mode stops at zero left
  assign active = (rate_ff != 4'h0) &&
    (const_mode || (left_ff != 10'h000));
  assign inject = group_end && active;

  always @* begin
    nxt_left = left_ff;
    if (load_pend_ff) begin
      nxt_left = {cnt_high_ff, cnt_low_ff};
    end else if (inject && !const_mode) begin
      nxt_left = left_ff - 10'h001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_prev_ff <= 1'b0;
      load_pend_ff <= 1'b0;
      left_ff      <= 10'h000;
      rate_ff      <= 4'h0;
    end else begin
      load_prev_ff <= erc_ff[`ERC_LOAD_BIT];
      // transfer lands the cycle after the edge is seen
      load_pend_ff <= load_rise;
      left_ff      <= nxt_left;
      if (tx_bit_valid && tx_frame_bit) begin
        rate_ff <= erc_ff[`ERC_RATE_MSB:`ERC_RATE_LSB];
      end
    end
  end

  // transmit path only; no receive side exists in this block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_valid_out <= 1'b0;
      tx_bit_out       <= 1'b0;
      error_inserted   <= 1'b0;
    end else begin
      tx_bit_valid_out <= tx_bit_valid;
      tx_bit_out       <= tx_bit_in ^ inject;
      error_inserted   <= inject;
    end
  end
endmodule

// ==== rtl/payload_error_inserter_regs.vh ====
// register offsets, field positions, reset values for the payload error inserter
// assumes byte addresses on a 32-bit APB bus, one register per word
`ifndef PAYLOAD_ERROR_INSERTER_REGS_VH
`define PAYLOAD_ERROR_INSERTER_REGS_VH

// printed offsets are not multiples of four: these are word indices
`define IDX_ERROR_RATE_CONTROL 8'hEB
`define IDX_ERROR_COUNT_LOW    8'hEC
`define IDX_ERROR_COUNT_HIGH   8'hED
`define IDX_ERRORS_LEFT_LOW    8'hEE
`define IDX_ERRORS_LEFT_HIGH   8'hEF
`define IDX_CHANNEL_SELECT     8'hF0
`define IDX_CONTROL            8'hF1

`define RST_ERROR_RATE_CONTROL 8'h00
`define RST_ERROR_COUNT_LOW    8'h00
`define RST_ERROR_COUNT_HIGH   8'h00
`define RST_CHANNEL_SELECT     24'h000000
`define RST_CONTROL            1'h0

`define ERC_RATE_LSB   0
`define ERC_RATE_MSB   3
`define ERC_CONST_BIT  4
`define ERC_LOAD_BIT   7
`define ERC_WRITE_MASK 8'h9F

`define RATE_BASE_LOG2 4
`define FRAME_SLOTS    193
`define CHANNEL_BITS   8
`define NUM_CHANNELS   24

`endif

// ==== rtl/error_spacing_counter.v ====
// counts payload bits and flags the last bit of each spaced group
// assumes bit_en is a one-cycle enable per counted payload bit
`timescale 1ns/100ps
module error_spacing_counter #(
  parameter CNT_W = 18
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             bit_en,
  input  wire             restart,
  input  wire [3:0]       rate_code,
  output wire             group_end
);
  `include "payload_error_inserter_regs.vh"

  reg  [CNT_W-1:0] count_ff;
  wire [CNT_W-1:0] nxt_count;
  wire [CNT_W-1:0] last_value;

  // group length is 2^(rate+3); rate 0 never ends a group
  assign last_value = (rate_code == 4'h0) ? {CNT_W{1'b1}} :
    ({{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, rate_code} + 5'h03)) - 1'b1;
  assign group_end = bit_en && (rate_code != 4'h0) &&
    (count_ff == last_value);
  assign nxt_count = (restart || group_end) ? {CNT_W{1'b0}} :
    bit_en ? count_ff + 1'b1 : count_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= {CNT_W{1'b0}};
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule

// ==== verification/payload_error_inserter_assertions.sv ====
// port-level checks on the payload error inserter
// assumes one pclk domain; bound from the bench top file
`timescale 1ns/100ps
module inserter_checker #(
  parameter CNT_W = 18
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        tx_bit_valid,
  input wire        tx_bit_in,
  input wire        tx_frame_bit,
  input wire [4:0]  tx_channel,
  input wire        tx_bit_valid_out,
  input wire        tx_bit_out,
  input wire        error_inserted
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [9:0] idx = paddr[11:2];
  wire       acc = psel && penable;
  a_frame_clean: assert property (tx_bit_valid && tx_frame_bit |=> !error_inserted)
    else $error("framing bit inverted");
  a_idle_clean: assert property (!tx_bit_valid |=> !error_inserted)
    else $error("error without input bit");
  a_out_follows: assert property (tx_bit_valid |=> tx_bit_valid_out)
    else $error("output bit missing");
  a_err_inverts: assert property (error_inserted |-> tx_bit_valid_out && tx_bit_out != $past(tx_bit_in))
    else $error("error bit not inverted");
  a_clean_copy: assert property (tx_bit_valid_out && !error_inserted |-> tx_bit_out == $past(tx_bit_in))
    else $error("clean bit altered");
  a_err_spacing: assert property (error_inserted |=> !error_inserted [*8])
    else $error("errors too close");
  a_zero_wait: assert property (acc |-> pready)
    else $error("wait state seen");
  a_unmapped_err: assert property (acc |-> pslverr == (idx < 10'h0EB || idx > 10'h0F1))
    else $error("slave error wrong");
  cover property (error_inserted);
  cover property (acc && pslverr);
  cover property (acc && pwrite && idx == 10'h0EB && pwdata[7]);
endmodule

// ==== verification/apb_host_model.sv ====
// host side of the register port, one apb transfer at a time
// assumes the bench calls xfer just after a rising pclk edge
`timescale 1ns/100ps
module apb_host_model (
  input  wire        pclk,
  input  wire        pready,
  input  wire [31:0] prdata,
  input  wire        pslverr,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  output reg         hung
);
  initial {psel, penable, pwrite, paddr, pwdata, hung} = 48'h0;
  task xfer(input w, input [11:0] a, input [31:0] d,
            output [31:0] q, output e);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (!pready && n < 16) begin
        @(posedge pclk);
        n = n + 1;
      end
      hung <= (n == 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next request never lands in this time step
      @(posedge pclk);
    end
  endtask
endmodule

// ==== verification/payload_error_inserter_tb_top.sv ====
// self-checking bench: apb host model plus a framed transmit stream
// assumes 193-bit frames, framing bit first, 8 bits per channel
`timescale 1ns/100ps
module payload_error_inserter_tb_top;
  localparam [11:0] ERROR_RATE_CONTROL = 12'h3AC;
  reg         pclk = 0, presetn = 0, run = 0, pay_q = 0, e;
  reg         tx_bit_valid = 0, tx_bit_in = 0, tx_frame_bit = 0;
  reg  [4:0]  tx_channel = 0, ch_q = 0;
  reg  [23:0] chmask = 24'hFFFFFF;
  reg  [7:0]  pos = 0;
  reg  [9:0]  n;
  reg  [31:0] q;
  integer     failures = 0, samples_checked = 0;
  integer     nbits, nerr, grp_n, k, i;
  wire        psel, penable, pwrite, pready, pslverr, hung;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire        tx_bit_valid_out, tx_bit_out, error_inserted;
  wire [7:0]  slot = pos - 8'h01;
  payload_error_inserter payload_error_inserter_inst (.*);
  apb_host_model apb_host_model_inst (.*);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    tx_bit_valid <= run;
    tx_frame_bit <= run && pos == 8'h00;
    tx_channel <= (pos == 8'h00) ? 5'h00 : slot[7:3];
    tx_bit_in <= $urandom;
    pos <= (!run || pos == 8'hC0) ? 8'h00 : pos + 8'h01;
    pay_q <= tx_bit_valid && !tx_frame_bit;
    ch_q <= tx_channel;
  end
  always @(posedge pclk) if (tx_bit_valid_out && pay_q) begin
    if (error_inserted)
      check("channel", chmask[ch_q], 1);
    if (chmask[ch_q]) begin
      nbits = nbits + 1;
      if (error_inserted) begin
        nerr = nerr + 1;
        check("spacing", nbits % grp_n, 0);
      end
    end
  end
  task stop_test;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task io(input w, input [11:0] a, input [31:0] d);
    begin
      apb_host_model_inst.xfer(w, a, d, q, e);
      if (hung) begin
        failures = failures + 1;
        stop_test;
      end
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      io(1'b0, a, 32'h0);
      check("readback", q, exp);
    end
  endtask
  task prog(input ce, input [3:0] code, input [9:0] cnt);
    begin
      run <= 1'b0;
      repeat (3) @(posedge pclk);
      io(1'b1, 12'h3B0, {24'h0, cnt[7:0]});
      io(1'b1, 12'h3B4, {30'h0, cnt[9:8]});
      io(1'b1, ERROR_RATE_CONTROL, {27'h0, ce, code});
      io(1'b1, ERROR_RATE_CONTROL, {24'h0, 3'b100, ce, code});
      repeat (2) @(posedge pclk);
      rd(12'h3B8, {24'h0, cnt[7:0]});
      rd(12'h3BC, {30'h0, cnt[9:8]});
      nbits = 0;
      nerr = 0;
      grp_n = 1 << (code + 3);
      run <= 1'b1;
    end
  endtask
  task await(input integer cnt, input integer lim);
    begin
      for (i = 0; nerr < cnt && i < lim; i = i + 1)
        @(posedge pclk);
      if (nerr < cnt) begin
        failures = failures + 1;
        stop_test;
      end
    end
  endtask
  initial begin
    q = $urandom(32'h2944);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 5; k = k + 1)
      rd(ERROR_RATE_CONTROL + 12'(4 * k), 32'h0);
    rd(12'h100, 32'h0);
    check("slverr", e, 1);
    io(1'b1, ERROR_RATE_CONTROL, 32'hFF);
    rd(ERROR_RATE_CONTROL, 32'h9F);
    $display("register test done");
    for (k = 0; k < 4; k = k + 1) begin
      n = (k == 0) ? 10'h0 : (k == 1) ? 10'h3FF : 10'($urandom_range(1, 30));
      prog(1'b0, k == 1 ? 4'h1 : 4'($urandom_range(1, 3)), n);
      await(n, n * grp_n * 2 + 600);
      repeat (2 * grp_n + 400) @(posedge pclk);
      check("errors", nerr, n);
      rd(12'h3B8, 32'h0);
    end
    // load bit left high: a second write must not reload the count
    io(1'b1, 12'h3B0, 32'h5);
    io(1'b1, ERROR_RATE_CONTROL, 32'h81);
    repeat (2) @(posedge pclk);
    rd(12'h3B8, 32'h0);
    $display("count mode test done");
    for (k = 0; k < 5; k = k + 1) begin
      prog(1'b1, k[3:0], 10'h0);
      await(k == 0 ? 0 : 3, 8 * grp_n + 600);
      repeat (400) @(posedge pclk);
      check("constant", nerr != 0, k != 0);
    end
    $display("constant mode test done");
    // only channels 3 and 8 count and may be hit
    run <= 1'b0;
    repeat (3) @(posedge pclk);
    io(1'b1, 12'h3C0, 32'h00000108);
    io(1'b1, 12'h3C4, 32'h00000001);
    chmask = 24'h000108;
    prog(1'b0, 4'h1, 10'h006);
    await(6, 4000);
    repeat (600) @(posedge pclk);
    check("chan_errs", nerr, 6);
    run <= 1'b0;
    repeat (3) @(posedge pclk);
    io(1'b1, 12'h3C4, 32'h00000000);
    chmask = 24'hFFFFFF;
    $display("channel mode test done");
    stop_test;
  end
endmodule
bind payload_error_inserter inserter_checker #(.CNT_W(CNT_W)) chk_inst (.*);
